// file: design/etp_timer.v
// Eight-bit event counter, square-wave and PWM timer with its register port.
// Operation
// - Event mode counts falling edges for select 00H, rising edges for 01H.
// - Clear-and-start mode clears counter on compare match and pulses the match interrupt.
// - Counting starts only after the count enable bit is written to one.
// - With inversion and output enabled, each match toggles the output flip-flop.
// - Square-wave frequency is one over twice period times compare plus one.
// - Mode bit 6 set selects free-running PWM operation.
// - In PWM mode bit 1 selects polarity: zero active-high, one active-low.
// - PWM stays inactive until first overflow, then active from overflow until match.
// - Writing count enable to zero drives the PWM output inactive.
// - PWM period is 256 count clocks, active width is compare times period.
// - PWM compare writes are buffered and transferred at overflow as timed.
// - Reading compare returns the newly written value before its transfer.
// - Counter start is asynchronous to the count clock, one-clock first-match error.
// - With output disabled the timer output pin is held low.
// - Output flip-flop set and reset bits are write-only and read as zero.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "etp_map.vh"
module etp_timer (
    // Clock and reset.
    input  wire       clk,
    input  wire       rst_n,
    // Register port.
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    // Pins.
    input  wire       event_input_pin,
    output reg        timer_output_pin,
    output reg        timer_output_oe,
    // Event.
    output reg        match_interrupt
);
    ////////////////////////////////////////////////////////////////////////////
    reg  [7:0]  event_counter_value_r;
    reg  [7:0]  compare_value_reg_r;
    reg  [7:0]  compare_active_r;
    reg         compare_pend_r;
    reg         compare_late_r;
    reg  [2:0]  count_clock_select_r;
    reg         count_enable_bit_r;
    reg         pwm_mode_bit_r;
    reg         invert_or_polarity_bit_r;
    reg         output_enable_bit_r;
    reg         out_ff_r;
    reg         pwm_act_r;
    reg         pin_direction_bit_r;
    reg         pin_output_latch_r;
    reg  [12:0] div_r;
    reg         tick;
    wire        ev_rise;
    wire        ev_fall;
    wire        wr_mode;
    wire        wr_cmp;
    wire        cmp_hit;
    wire        ovf;

    assign wr_mode = wr && (addr == `ETP_ADDR_MODE);
    assign wr_cmp  = wr && (addr == `ETP_ADDR_COMPARE);

    etp_edge_sync u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_in (event_input_pin),
        .rise_r (ev_rise),
        .fall_r (ev_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler runs freely, so the first count after enable lands anywhere within a
    // count period; that start error is inherent and accepted.
    always @(posedge clk) begin
        if (!rst_n) begin
            div_r <= 13'h0000;
        end else begin
            div_r <= div_r + 13'h0001;
        end
    end

    always @* begin
        case (count_clock_select_r)
            `ETP_CKS_FALL: tick = ev_fall;
            `ETP_CKS_RISE: tick = ev_rise;
            3'h2: tick = 1'b1;
            3'h3: tick = &div_r[`ETP_DIV_X2 - 1:0];
            3'h4: tick = &div_r[`ETP_DIV_X4 - 1:0];
            3'h5: tick = &div_r[`ETP_DIV_X64 - 1:0];
            3'h6: tick = &div_r[`ETP_DIV_X256 - 1:0];
            default: tick = &div_r[`ETP_DIV_X8192 - 1:0];
        endcase
    end

    assign cmp_hit = event_counter_value_r == compare_value_reg_r;
    assign ovf     = event_counter_value_r == 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (!rst_n) begin
            event_counter_value_r    <= 8'h00;
            compare_value_reg_r      <= `ETP_RST_COMPARE;
            compare_active_r         <= `ETP_RST_COMPARE;
            compare_pend_r           <= 1'b0;
            compare_late_r           <= 1'b0;
            count_clock_select_r     <= 3'h0;
            count_enable_bit_r       <= 1'b0;
            pwm_mode_bit_r           <= 1'b0;
            invert_or_polarity_bit_r <= 1'b0;
            output_enable_bit_r      <= 1'b0;
            out_ff_r                 <= 1'b0;
            pwm_act_r                <= 1'b0;
            pin_direction_bit_r      <= 1'b1;
            pin_output_latch_r       <= 1'b1;
            match_interrupt          <= 1'b0;
        end else begin
            match_interrupt <= 1'b0;
            if (wr && addr == `ETP_ADDR_CLKSEL) begin
                count_clock_select_r <= wdata[2:0];
            end
            if (wr && addr == `ETP_ADDR_PORT) begin
                pin_direction_bit_r <= wdata[`ETP_PORT_DIR];
                pin_output_latch_r  <= wdata[`ETP_PORT_LATCH];
            end
            if (wr_cmp) begin
                compare_value_reg_r <= wdata;
                compare_pend_r      <= 1'b1;
                // A write that finds the count already at FF misses this overflow.
                compare_late_r      <= ovf;
                if (!count_enable_bit_r || !pwm_mode_bit_r) begin
                    compare_active_r <= wdata;
                    compare_pend_r   <= 1'b0;
                    compare_late_r   <= 1'b0;
                end
            end
            if (wr_mode) begin
                count_enable_bit_r       <= wdata[`ETP_MODE_CE];
                pwm_mode_bit_r           <= wdata[`ETP_MODE_PWM];
                invert_or_polarity_bit_r <= wdata[`ETP_MODE_INV];
                output_enable_bit_r      <= wdata[`ETP_MODE_OE];
                if (!wdata[`ETP_MODE_CE]) begin
                    event_counter_value_r <= 8'h00;
                    pwm_act_r             <= 1'b0;
                    compare_active_r      <= compare_value_reg_r;
                    compare_pend_r        <= 1'b0;
                    compare_late_r        <= 1'b0;
                end
                if (!wdata[`ETP_MODE_PWM] && wdata[`ETP_MODE_SET] && !wdata[`ETP_MODE_RST]) begin
                    out_ff_r <= 1'b1;
                end else if (!wdata[`ETP_MODE_PWM] && !wdata[`ETP_MODE_SET]
                             && wdata[`ETP_MODE_RST]) begin
                    out_ff_r <= 1'b0;
                end
            end else if (count_enable_bit_r && tick) begin
                if (pwm_mode_bit_r) begin
                    event_counter_value_r <= event_counter_value_r + 8'h01;
                    if (ovf) begin
                        // Zero width: active level never shows.
                        pwm_act_r <= (compare_pend_r && !compare_late_r && !wr_cmp) ?
                                     (compare_value_reg_r != 8'h00) :
                                     (compare_active_r != 8'h00);
                        if (compare_pend_r && !compare_late_r && !wr_cmp) begin
                            compare_active_r <= compare_value_reg_r;
                            compare_pend_r   <= 1'b0;
                        end else if (!wr_cmp) begin
                            compare_late_r   <= 1'b0;
                        end
                    end else if (event_counter_value_r + 8'h01 == compare_active_r) begin
                        pwm_act_r <= 1'b0;
                    end
                end else if (cmp_hit) begin
                    event_counter_value_r <= 8'h00;
                    match_interrupt       <= 1'b1;
                    if (invert_or_polarity_bit_r) begin
                        out_ff_r <= ~out_ff_r;
                    end
                end else begin
                    event_counter_value_r <= event_counter_value_r + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive: PWM uses the active flag through the polarity bit.
    always @(posedge clk) begin
        if (!rst_n) begin
            timer_output_pin <= 1'b0;
            timer_output_oe  <= 1'b0;
        end else begin
            timer_output_oe <= ~pin_direction_bit_r;
            if (pin_direction_bit_r) begin
                timer_output_pin <= 1'b0;
            end else if (!output_enable_bit_r) begin
                timer_output_pin <= 1'b0;
            end else if (pwm_mode_bit_r) begin
                timer_output_pin <= pwm_act_r ^ invert_or_polarity_bit_r;
            end else begin
                timer_output_pin <= out_ff_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == `ETP_ADDR_COUNT) begin
                rdata <= event_counter_value_r;
            end else if (addr == `ETP_ADDR_COMPARE) begin
                rdata <= compare_value_reg_r;
            end else if (addr == `ETP_ADDR_CLKSEL) begin
                rdata <= {5'h00, count_clock_select_r};
            end else if (addr == `ETP_ADDR_MODE) begin
                rdata <= {count_enable_bit_r, pwm_mode_bit_r, 4'h0,
                          invert_or_polarity_bit_r, output_enable_bit_r};
            end else if (addr == `ETP_ADDR_PORT) begin
                rdata <= {6'h00, pin_direction_bit_r, pin_output_latch_r};
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // etp_timer
`default_nettype wire

// file: design/etp_map.vh
// Register offsets, field positions, reset values and timing counts for the event timer.
`ifndef ETP_MAP_VH
`define ETP_MAP_VH
// Register offsets (byte addresses).
`define ETP_ADDR_COUNT     8'h00
`define ETP_ADDR_COMPARE   8'h04
`define ETP_ADDR_CLKSEL    8'h08
`define ETP_ADDR_MODE      8'h0c
`define ETP_ADDR_PORT      8'h10
// Mode control fields.
`define ETP_MODE_CE        7
`define ETP_MODE_PWM       6
`define ETP_MODE_SET       3
`define ETP_MODE_RST       2
`define ETP_MODE_INV       1
`define ETP_MODE_OE        0
// Port fields.
`define ETP_PORT_DIR       1
`define ETP_PORT_LATCH     0
// Clock select codes.
`define ETP_CKS_FALL       3'h0
`define ETP_CKS_RISE       3'h1
// Reset values.
`define ETP_RST_MODE       8'h00
`define ETP_RST_CLKSEL     8'h00
`define ETP_RST_COMPARE    8'h00
`define ETP_RST_PORT       2'h3
// Divider exponents for the internal count clock choices.
`define ETP_DIV_X1         4'h0
`define ETP_DIV_X2         4'h1
`define ETP_DIV_X4         4'h2
`define ETP_DIV_X64        4'h6
`define ETP_DIV_X256       4'h8
`define ETP_DIV_X8192      4'hd
`endif

// file: design/etp_edge_sync.v
// Three-stage pin synchroniser with registered edge detection.
`timescale 1ns/1ns
`default_nettype none
module etp_edge_sync (
    // Clock and reset.
    input  wire clk,
    input  wire rst_n,
    // Pin and edge pulses.
    input  wire pin_in,
    output reg  rise_r,
    output reg  fall_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg lvl_r;

    // The first stage feeds only the second; the edge is judged on stages two and three.
    always @(posedge clk) begin
        if (!rst_n) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            lvl_r  <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            s1_r   <= pin_in;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            // A change counts only once stages two and three agree, so a one-cycle glitch is lost.
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
            rise_r <= (s2_r == s3_r) && s3_r && !lvl_r;
            fall_r <= (s2_r == s3_r) && !s3_r && lvl_r;
        end
    end
endmodule // etp_edge_sync
`default_nettype wire

// file: test/etp_timer_monitor.sv
// Port assertions for the event timer.
`timescale 1ns/1ns
`default_nettype none
module etp_timer_monitor (
    // Watched ports.
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       timer_output_pin,
    input wire logic       timer_output_oe,
    input wire logic       match_interrupt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic pwm_r;
    // The mode bit is shadowed so a match can be tied to the running mode.
    always @(posedge clk) begin
        if (!rst_n) pwm_r <= 1'b0;
        else if (wr && addr == 8'h0c) pwm_r <= wdata[6];
    end
    property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_irq_pulse; match_interrupt |=> !match_interrupt; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("match pulse too long");
    property p_oe_low; !timer_output_oe |-> !timer_output_pin; endproperty
    a_oe_low: assert property (p_oe_low) else $error("pin high while undriven");
    property p_ff_bits; rd && addr == 8'h0c |=> rdata[3:2] == 2'b00; endproperty
    a_ff_bits: assert property (p_ff_bits) else $error("set or reset bit read back");
    property p_out_off;
        (wr && addr == 8'h0c && !wdata[0]) ##1 (!wr)[*3] |-> !timer_output_pin;
    endproperty
    a_out_off: assert property (p_out_off) else $error("pin high with output off");
    property p_pwm_stop;
        (wr && addr == 8'h0c && wdata[7:6] == 2'b01 && !wdata[1]) ##1 (!wr)[*3]
            |-> !timer_output_pin;
    endproperty
    a_pwm_stop: assert property (p_pwm_stop) else $error("stopped pwm not inactive");
    property p_dir_in;
        (wr && addr == 8'h10 && wdata[1]) ##1 !(wr && addr == 8'h10) |=> !timer_output_oe;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("pin driven in input mode");
    property p_cmp_rb;
        (wr && addr == 8'h04) ##1 !wr ##1 (rd && addr == 8'h04) |=> rdata == $past(wdata, 3);
    endproperty
    a_cmp_rb: assert property (p_cmp_rb) else $error("compare read not new value");
    property p_irq_mode; pwm_r && $past(pwm_r) |-> !match_interrupt; endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("match pulse in pwm mode");
    cover property (match_interrupt);
    cover property ($fell(timer_output_pin) && timer_output_oe);
    cover property (rd && addr == 8'h04);
endmodule // etp_timer_monitor
bind etp_timer etp_timer_monitor etp_timer_monitor_inst (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .match_interrupt(match_interrupt));
`default_nettype wire

// file: test/etp_pin_side.sv
// Event pulse source and output load on the timer pins.
`timescale 1ns/1ns
`default_nettype none
module etp_pin_side (
    // Control.
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [7:0] n,
    // Pins and observations.
    input  wire logic       timer_output_pin,
    output logic            event_input_pin,
    output logic            busy,
    output logic [8:0]      high_len
);
    logic [8:0] left_r;
    logic [3:0] ph_r;
    logic [8:0] cnt_r;
    initial begin
        event_input_pin = 1'b0;
        left_r = 9'h000;
        ph_r = 4'h0;
        cnt_r = 9'h000;
        high_len = 9'h000;
    end
    assign busy = left_r != 9'h000;
    // Whole pulses only, so the pin always rests low between bursts.
    always @(posedge clk) begin
        ph_r <= ph_r + 4'h1;
        if (go) left_r <= {n, 1'b0};
        else if (busy && (ph_r == 4'hf || (!slow && ph_r[1:0] == 2'h3))) begin
            event_input_pin <= ~event_input_pin;
            left_r <= left_r - 9'h001;
        end
        cnt_r <= timer_output_pin ? cnt_r + 9'h001 : 9'h000;
        if (cnt_r != 9'h000 && !timer_output_pin) high_len <= cnt_r;
    end
endmodule // etp_pin_side
`default_nettype wire

// file: test/etp_timer_tb.sv
// Self-checking bench for the event timer.
`timescale 1ns/1ns
`default_nettype none
module etp_timer_tb;
    logic       clk, rst_n, wr, rd, go, slow, pin, oe, irq, ev, busy;
    logic [7:0] addr, wdata, rdata, n;
    logic [8:0] high_len;
    int         mismatches, n_tests, cycles, irqs, base;
    etp_timer etp_timer_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .event_input_pin(ev), .timer_output_pin(pin),
        .timer_output_oe(oe), .match_interrupt(irq));
    etp_pin_side etp_pin_side_inst (.clk(clk), .go(go), .slow(slow), .n(n),
        .timer_output_pin(pin), .event_input_pin(ev), .busy(busy), .high_len(high_len));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results;
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check({1'b0, rdata}, {1'b0, exp});
    endtask
    // The fixed settle after a burst covers the pin synchroniser latency.
    task automatic pulses(input logic [7:0] k);
        @(posedge clk);
        n <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        for (int i = 0; i < 600 && busy !== 1'b0; i++) @(negedge clk);
        repeat (8) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {mismatches, n_tests, cycles, irqs} = '0;
        {rst_n, wr, rd, go, slow, addr, wdata, n} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h10, 8'h03);
        rd_chk(8'h20, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr_reg(8'h0c, 8'h00);
            wr_reg(8'h08, s[7:0]);
            wr_reg(8'h04, 8'hff);
            pulses(8'h02);
            rd_chk(8'h00, 8'h00);
            wr_reg(8'h0c, 8'h80);
            slow <= s[0];
            pulses(8'h05);
            rd_chk(8'h00, 8'h05);
        end
        wr_reg(8'h0c, 8'h00);
        wr_reg(8'h04, 8'h03);
        wr_reg(8'h0c, 8'h80);
        base = irqs;
        pulses(8'h05);
        rd_chk(8'h00, 8'h01);
        check(9'(irqs - base), 9'h001);
        wr_reg(8'h0c, 8'h00);
        wr_reg(8'h10, 8'h00);
        wr_reg(8'h08, 8'h02);
        wr_reg(8'h04, 8'h09);
        wr_reg(8'h0c, 8'h0b);
        rd_chk(8'h0c, 8'h03);
        wr_reg(8'h0c, 8'h83);
        repeat (100) @(posedge clk);
        check(high_len, 9'h00a);
        wr_reg(8'h0c, 8'h00);
        repeat (3) @(posedge clk);
        check({8'h00, pin}, 9'h000);
        wr_reg(8'h0c, 8'h41);
        wr_reg(8'h04, 8'h40);
        wr_reg(8'h0c, 8'hc1);
        repeat (600) @(posedge clk);
        check(high_len, 9'h040);
        wr_reg(8'h04, 8'h20);
        rd_chk(8'h04, 8'h20);
        repeat (600) @(posedge clk);
        check(high_len, 9'h020);
        wr_reg(8'h0c, 8'h41);
        repeat (3) @(posedge clk);
        check({8'h00, pin}, 9'h000);
        wr_reg(8'h0c, 8'h43);
        wr_reg(8'h0c, 8'hc3);
        repeat (10) @(posedge clk);
        check({8'h00, pin}, 9'h001);
        repeat (600) @(posedge clk);
        check(high_len, 9'h0e0);
        wr_reg(8'h0c, 8'h43);
        repeat (3) @(posedge clk);
        check({8'h00, pin}, 9'h001);
        results();
    end
endmodule // etp_timer_tb
`default_nettype wire
